// ---- rtl/pcstk_pkg.sv ----
// Constants, register indices and carrier types for the program flow core.
// Assumes a single core clock shared by decoder, interrupt logic and data memory.
package pcstk_pkg;
    localparam int PC_W        = 13;
    localparam int STK_DEPTH   = 8;
    localparam int HOLD_W      = 5;
    localparam int TGT_W       = 11;
    localparam int FADDR_W     = 8;
    localparam int EADDR_W     = 9;
    localparam int APB_AW      = 12;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_IND    = 8'h00;
    localparam logic [7:0] IDX_PCL    = 8'h02;
    localparam logic [7:0] IDX_STATUS = 8'h03;
    localparam logic [7:0] IDX_PTR    = 8'h04;
    localparam logic [7:0] IDX_HOLD   = 8'h0A;
    localparam logic [7:0] IDX_FLAG   = 8'h0C;
    localparam logic [7:0] IDX_EN     = 8'h8C;
    localparam logic [7:0] IDX_CAUSE  = 8'h8E;

    localparam int CAUSE_POR_BIT   = 1;
    localparam int CAUSE_BOR_BIT   = 0;
    localparam int STATUS_BANK_BIT = 7;
    localparam int HOLD_CG_HI      = 4;
    localparam int HOLD_CG_LO      = 3;
    localparam int IND_SELF_W      = 7;

    localparam logic [PC_W-1:0]   PC_RESET    = 13'h0000;
    localparam logic [PC_W-1:0]   PC_VECTOR   = 13'h0004;
    localparam logic [7:0]        CAUSE_RESET = 8'h00;
    localparam logic [7:0]        CAUSE_MASK  = 8'h03;
    localparam logic [HOLD_W-1:0] HOLD_RESET  = 5'h00;
    localparam logic [7:0]        BYTE_ZERO   = 8'h00;

    typedef struct packed {
        logic                step;
        logic                pcl_wr;
        logic [7:0]          pcl_data;
        logic                jump;
        logic                call;
        logic [TGT_W-1:0]    target;
        logic                vector;
        logic                ret;
    } flow_req_s;

    typedef struct packed {
        logic                rd;
        logic                wr;
        logic [FADDR_W-1:0]  addr;
    } file_req_s;

    typedef struct packed {
        logic                rd;
        logic                wr;
        logic [EADDR_W-1:0]  addr;
        logic                zero;
    } mem_acc_s;

    function automatic logic [APB_AW-1:0] reg_byte_addr(input logic [7:0] idx);
        reg_byte_addr = {2'b00, idx, 2'b00};
    endfunction : reg_byte_addr
endpackage : pcstk_pkg

// ---- rtl/ret_stack.sv ----
// Circular return stack with a hidden wrapping pointer.
// Assumes push and pop are never requested in the same cycle.
`timescale 1ns/1ps
module ret_stack
    import pcstk_pkg::*;
#(
    parameter int DEPTH = STK_DEPTH,
    parameter int WIDTH = PC_W
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] top
);
    localparam int PW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin
            $error("ret_stack depth must be a power of two");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    ptr_r;

    // No full or empty flag exists; the pointer simply wraps.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_r <= '0;
        end else if (push) begin
            ptr_r <= ptr_r + 1'b1; // (RL16) (RL17) (RL22)
        end else if (pop) begin
            ptr_r <= ptr_r - 1'b1; // (RL22)
        end
    end

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[ptr_r] <= din; // (RL12) (RL16)
        end
    end

    assign top = mem[PW'(ptr_r - 1'b1)]; // (RL22)

    a_push_wrap: assert property (@(posedge pclk) disable iff (!presetn) // (RL16)
        push && ptr_r == PW'(DEPTH - 1) |=> ptr_r == '0)
        else $error("stack pointer did not wrap on push");

    a_lifo_top: assert property (@(posedge pclk) disable iff (!presetn) // (RL22)
        push |=> top == $past(din))
        else $error("pushed value is not on top");
endmodule : ret_stack

// ---- rtl/pc_stack_indirect_core.sv ----
// Program counter, return stack, indirect addressing, reset cause and peripheral flags.
// Assumes the decoder, interrupt logic and data memory share pclk; APB registers.
//
// Operation
// (RL1) Peripheral flags set on their event regardless of enable bits.
// (RL2) Software clears stale flags before enabling the matching interrupt.
// (RL3) Cause bit 1 reads 0 after power-on, hardware only clears it.
// (RL4) Cause bit 0 cleared by brown-out reset; software sets it afterwards.
// (RL5) Brown-out bit undefined after power-on or with the circuit disabled.
// (RL6) Upper six cause bits always read zero.
// (RL7) Program counter is 13 bits; low byte readable, upper bits hidden.
// (RL8) Every reset clears the program counter.
// (RL9) Low byte write loads upper bits from holding bits 4 to 0.
// (RL10) Call or goto take top two bits from holding bits 4 and 3.
// (RL11) Computed jumps do not carry; software keeps tables in 256 words.
// (RL12) Return stack holds 8 entries of 13 bits, pointer hidden.
// (RL13) Calls and interrupt vectoring push the current program counter.
// (RL14) Return, return with literal and interrupt return pop the stack.
// (RL15) Pushes and pops leave the holding register unchanged.
// (RL16) Stack is circular; the ninth push overwrites the first entry.
// (RL17) No overflow or underflow status exists.
// (RL18) Indirect port has no storage; accesses go to pointed location.
// (RL19) Indirect read of the indirect port itself returns zero.
// (RL20) Indirect write of the indirect port itself stores nothing.
// (RL21) Effective address is bank bit over 8-bit pointer; bank unused.
// (RL22) Stack is last-in first-out with a pointer wrapping modulo eight.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module pc_stack_indirect_core
    import pcstk_pkg::*;
#(
    parameter int  DEPTH     = STK_DEPTH,
    parameter bit  BANK_USED = 1'b0
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              por_rstn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire flow_req_s         flow,
    input  wire file_req_s         file,
    input  wire logic [7:0]        irq_event,
    input  wire logic              brownout_flag,
    input  wire logic              brownout_circuit_enable_cfg,
    output logic      [PC_W-1:0]   pc,
    output mem_acc_s               mem,
    output logic                   irq_pending
);
    initial begin
        if (DEPTH != STK_DEPTH) begin
            $error("return stack depth must be eight");
        end
    end

    logic [PC_W-1:0]   pc_r;
    logic [PC_W-1:0]   pc_nxt;
    logic [HOLD_W-1:0] hold_r;
    logic [7:0]        ptr_r;
    logic              bank_r;
    logic [7:0]        flag_r;
    logic [7:0]        en_r;
    logic [7:0]        cause_r;
    logic              first_r;
    logic [1:0]        bor_sync_r;
    logic [1:0]        brownout_circuit_enable_cfg_sync_r;
    logic              pready_r;
    logic              pslverr_r;
    logic [31:0]       prdata_r;
    logic [31:0]       rd_nxt;
    logic              hit_nxt;
    mem_acc_s          mem_r;
    logic              irq_r;
    logic [PC_W-1:0]   stk_top;
    logic              push;
    logic              pop;
    logic              apb_wr;
    logic [7:0]        idx;
    logic              ind_sel;
    logic              ind_self;

    function automatic logic idx_ok(input logic [APB_AW-1:0] a);
        idx_ok = (a[1:0] == 2'b00) && (a[APB_AW-1:10] == '0);
    endfunction : idx_ok

    assign idx    = paddr[9:2];
    assign apb_wr = psel && penable && pready_r && pwrite && !pslverr_r;

    // Stack traffic follows the flow requests of the decoder.
    assign push = flow.vector || (!flow.ret && flow.jump && flow.call); // (RL13)
    assign pop  = !flow.vector && flow.ret; // (RL14)

    ret_stack #(
        .DEPTH (DEPTH),
        .WIDTH (PC_W)
    ) u_stack (
        .pclk    (pclk),
        .presetn (presetn),
        .push    (push),
        .pop     (pop),
        .din     (pc_r),
        .top     (stk_top)
    );

    // Vectoring beats a return, which beats a jump, a low byte load and a step.
    always_comb begin
        pc_nxt = pc_r;
        if (flow.vector) begin
            pc_nxt = PC_VECTOR; // (RL13)
        end else if (flow.ret) begin
            pc_nxt = stk_top; // (RL14)
        end else if (flow.jump) begin
            pc_nxt = {hold_r[HOLD_CG_HI:HOLD_CG_LO], flow.target}; // (RL10)
        end else if (flow.pcl_wr) begin
            pc_nxt = {hold_r, flow.pcl_data}; // (RL9)
        end else if (apb_wr && idx == IDX_PCL) begin
            pc_nxt = {hold_r, pwdata[7:0]}; // (RL9)
        end else if (flow.step) begin
            pc_nxt = pc_r + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_r <= PC_RESET; // (RL8)
        end else begin
            pc_r <= pc_nxt; // (RL7)
        end
    end

    // The holding register only changes by software writes, never by stack traffic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= HOLD_RESET;
        end else if (apb_wr && idx == IDX_HOLD) begin
            hold_r <= pwdata[HOLD_W-1:0]; // (RL15)
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_r  <= BYTE_ZERO;
            bank_r <= 1'b0;
        end else begin
            if (apb_wr && idx == IDX_PTR) begin
                ptr_r <= pwdata[7:0];
            end
            if (apb_wr && idx == IDX_STATUS) begin
                bank_r <= pwdata[STATUS_BANK_BIT];
            end
        end
    end

    // A flag event in the same cycle as a software clear still sets the flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= BYTE_ZERO;
        end else if (apb_wr && idx == IDX_FLAG) begin
            flag_r <= pwdata[7:0] | irq_event; // (RL1)
        end else begin
            flag_r <= flag_r | irq_event; // (RL1)
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r  <= BYTE_ZERO;
            irq_r <= 1'b0;
        end else begin
            if (apb_wr && idx == IDX_EN) begin
                en_r <= pwdata[7:0];
            end
            irq_r <= |(flag_r & en_r);
        end
    end

    // Brown-out status arrives from the reset circuitry, outside this clock.
    always_ff @(posedge pclk or negedge por_rstn) begin
        if (!por_rstn) begin
            bor_sync_r   <= 2'b00;
            brownout_circuit_enable_cfg_sync_r <= 2'b00;
        end else begin
            bor_sync_r   <= {bor_sync_r[0], brownout_flag};
            brownout_circuit_enable_cfg_sync_r <= {brownout_circuit_enable_cfg_sync_r[0], brownout_circuit_enable_cfg};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    // Cause bits survive ordinary resets; only power-on reset initialises them.
    always_ff @(posedge pclk or negedge por_rstn) begin
        if (!por_rstn) begin
            cause_r <= CAUSE_RESET; // (RL3) (RL5)
        end else begin
            if (apb_wr && idx == IDX_CAUSE) begin
                cause_r <= pwdata[7:0] & CAUSE_MASK; // (RL6)
            end
            if (first_r && bor_sync_r[1] && brownout_circuit_enable_cfg_sync_r[1]) begin
                cause_r[CAUSE_BOR_BIT] <= 1'b0; // (RL4)
            end
        end
    end

    // Indirect accesses are steered to the pointed location each cycle.
    assign ind_sel  = (file.addr == IDX_IND); // (RL18)
    assign ind_self = ind_sel && (ptr_r[IND_SELF_W-1:0] == IDX_IND[IND_SELF_W-1:0]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_r <= '0;
        end else begin
            mem_r.rd   <= file.rd && !ind_self; // (RL19)
            mem_r.wr   <= file.wr && !ind_self; // (RL20)
            mem_r.zero <= file.rd && ind_self; // (RL19)
            if (ind_sel) begin
                mem_r.addr <= {BANK_USED & bank_r, ptr_r}; // (RL21)
            end else begin
                mem_r.addr <= {1'b0, file.addr};
            end
        end
    end

    always_comb begin
        rd_nxt  = '0;
        hit_nxt = 1'b1;
        unique case (idx)
            IDX_IND:    rd_nxt[7:0] = BYTE_ZERO;
            IDX_PCL:    rd_nxt[7:0] = pc_r[7:0]; // (RL7)
            IDX_STATUS: rd_nxt[STATUS_BANK_BIT] = bank_r;
            IDX_PTR:    rd_nxt[7:0] = ptr_r;
            IDX_HOLD:   rd_nxt[HOLD_W-1:0] = hold_r;
            IDX_FLAG:   rd_nxt[7:0] = flag_r;
            IDX_EN:     rd_nxt[7:0] = en_r;
            IDX_CAUSE:  rd_nxt[7:0] = cause_r & CAUSE_MASK; // (RL6)
            default:    hit_nxt = 1'b0;
        endcase
        if (!idx_ok(paddr)) begin
            hit_nxt = 1'b0;
        end
        if (!hit_nxt) begin
            rd_nxt = '0;
        end
    end

    // No wait state: the answer is registered in the setup cycle and ready in the access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else if (psel && !penable && !pready_r) begin
            pready_r  <= 1'b1;
            pslverr_r <= !hit_nxt;
            prdata_r  <= pwrite ? 32'h0000_0000 : rd_nxt;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end
    end

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign pc          = pc_r;
    assign mem         = mem_r;
    assign irq_pending = irq_r;

    a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn) // (RL1)
        |irq_event |=> (flag_r & $past(irq_event)) == $past(irq_event))
        else $error("peripheral flag missed its event");

    a_pcl_load: assert property (@(posedge pclk) disable iff (!presetn) // (RL9)
        flow.pcl_wr && !flow.jump && !flow.ret && !flow.vector
        |=> pc_r == {$past(hold_r), $past(flow.pcl_data)})
        else $error("low byte write did not load upper bits");

    a_jump_upper: assert property (@(posedge pclk) disable iff (!presetn) // (RL10)
        flow.jump && !flow.ret && !flow.vector
        |=> pc_r[PC_W-1:PC_W-2] == $past(hold_r[HOLD_CG_HI:HOLD_CG_LO])
            && pc_r[TGT_W-1:0] == $past(flow.target))
        else $error("jump target upper bits wrong");

    a_reset_pc: assert property (@(posedge pclk) // (RL8)
        !presetn |-> pc_r == PC_RESET)
        else $error("program counter not cleared by reset");

    a_ret_pops: assert property (@(posedge pclk) disable iff (!presetn) // (RL14)
        flow.call && flow.jump && !flow.ret && !flow.vector ##1 flow.ret && !flow.vector
        |=> pc_r == $past(pc_r, 2))
        else $error("return did not restore the pushed address");

    a_hold_kept: assert property (@(posedge pclk) disable iff (!presetn) // (RL15)
        (push || pop) && !(apb_wr && idx == IDX_HOLD) |=> $stable(hold_r))
        else $error("holding register changed by stack traffic");

    a_ind_self: assert property (@(posedge pclk) disable iff (!presetn) // (RL19)
        file.rd && ind_self |=> mem_r.zero && !mem_r.rd)
        else $error("self indirect read not zero");

    a_ind_nowr: assert property (@(posedge pclk) disable iff (!presetn) // (RL20)
        file.wr && ind_self |=> !mem_r.wr)
        else $error("self indirect write reached memory");

    a_cause_hi: assert property (@(posedge pclk) disable iff (!por_rstn) // (RL6)
        cause_r[7:2] == '0)
        else $error("unimplemented cause bits not zero");

    a_ind_addr: assert property (@(posedge pclk) disable iff (!presetn) // (RL21)
        ind_sel && (file.rd || file.wr) && !BANK_USED |=> mem_r.addr == {1'b0, $past(ptr_r)})
        else $error("indirect address not taken from pointer");

    a_vector_pc: assert property (@(posedge pclk) disable iff (!presetn) // (RL13)
        flow.vector |=> pc_r == PC_VECTOR && stk_top == $past(pc_r))
        else $error("vectoring did not push the program counter");

    a_call_push: assert property (@(posedge pclk) disable iff (!presetn) // (RL13)
        flow.jump && flow.call && !flow.ret && !flow.vector |=> stk_top == $past(pc_r))
        else $error("call did not push the program counter");

    a_pop_load: assert property (@(posedge pclk) disable iff (!presetn) // (RL14)
        flow.ret && !flow.vector |=> pc_r == $past(stk_top))
        else $error("return did not load the stack top");

    a_apb_pcl: assert property (@(posedge pclk) disable iff (!presetn) // (RL9)
        apb_wr && idx == IDX_PCL && !flow.vector && !flow.ret && !flow.jump && !flow.pcl_wr
        |=> pc_r == {$past(hold_r), $past(pwdata[7:0])})
        else $error("bus write of the low byte did not load upper bits");

    a_flag_write: assert property (@(posedge pclk) disable iff (!presetn) // (RL1)
        apb_wr && idx == IDX_FLAG |=> flag_r == ($past(pwdata[7:0]) | $past(irq_event)))
        else $error("flag write lost a same-cycle event");

    a_bor_clear: assert property (@(posedge pclk) disable iff (!por_rstn) // (RL4)
        first_r && bor_sync_r[1] && brownout_circuit_enable_cfg_sync_r[1] |=> !cause_r[CAUSE_BOR_BIT])
        else $error("brown-out reset did not clear its cause bit");
endmodule : pc_stack_indirect_core

// ---- verification/data_mem_model.sv ----
// Data memory stand-in that counts the accesses the core issues.
// Assumes the core's registered one-cycle access pulses on pclk.
`timescale 1ns/1ps
module data_mem_model
    import pcstk_pkg::*;
(
    input  wire logic         pclk,
    input  wire mem_acc_s     mem,
    output int                rd_count,
    output int                wr_count,
    output logic [EADDR_W-1:0] last_addr
);
    int rd_n = 0;
    int wr_n = 0;

    assign rd_count = rd_n;
    assign wr_count = wr_n;

    // A self-addressed indirect write must not reach here, so the count shows it.
    always @(posedge pclk) begin
        if (mem.rd === 1'b1 || mem.wr === 1'b1) begin
            last_addr <= mem.addr;
        end
        if (mem.rd === 1'b1) begin
            rd_n <= rd_n + 1;
        end
        if (mem.wr === 1'b1) begin
            wr_n <= wr_n + 1;
        end
    end
endmodule : data_mem_model

// ---- verification/pc_stack_indirect_core_test.sv ----
// Self-checking bench for the program flow core.
// Assumes the APB slave answers after one access cycle and a 50 MHz clock.
`timescale 1ns/1ps
module pc_stack_indirect_core_test;
    import pcstk_pkg::*;
    logic              pclk;
    logic              presetn;
    logic              por_rstn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    flow_req_s         flow;
    file_req_s         file;
    logic [7:0]        irq_event;
    logic              brownout_flag;
    logic              bo_cfg;
    logic [PC_W-1:0]   pc;
    mem_acc_s          mem;
    logic              irq_pending;
    int                rd_count;
    int                wr_count;
    logic [EADDR_W-1:0] last_addr;
    int                num_errors = 0;
    int                num_checks = 0;
    int                cycles = 0;

    pc_stack_indirect_core DUT (.pclk(pclk), .presetn(presetn), .por_rstn(por_rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flow(flow), .file(file), .irq_event(irq_event),
        .brownout_flag(brownout_flag), .brownout_circuit_enable_cfg(bo_cfg), .pc(pc), .mem(mem),
        .irq_pending(irq_pending));
    data_mem_model mem_side (.pclk(pclk), .mem(mem), .rd_count(rd_count), .wr_count(wr_count),
        .last_addr(last_addr));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    // The whole run needs under two hundred cycles; this ceiling only catches a hang.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wreg(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx, wd, rd, err);
        check({31'h0, err}, 32'h0, "bus error on write");
    endtask : wreg

    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx, 8'h00, rd, err);
        check({31'h0, err}, 32'h0, "bus error on read");
        check(rd, {24'h000000, exp}, "register read");
    endtask : rchk

    function automatic flow_req_s fj(input logic c, input logic [TGT_W-1:0] t);
        fj = '0;
        fj.jump = 1'b1;
        fj.call = c;
        fj.target = t;
    endfunction : fj

    task automatic flow_op(input flow_req_s f, input logic [PC_W-1:0] exp);
        @(posedge pclk);
        flow <= f;
        @(posedge pclk);
        flow <= '0;
        #1;
        check({19'h0, pc}, {19'h0, exp}, "program counter");
    endtask : flow_op

    task automatic file_op(input logic r, input logic w, input logic [7:0] a, input logic [2:0] exp);
        @(posedge pclk);
        file <= file_req_s'({r, w, a});
        @(posedge pclk);
        file <= '0;
        #1;
        check({29'h0, mem.rd, mem.wr, mem.zero}, {29'h0, exp}, "memory strobes");
    endtask : file_op

    task automatic pin_reset(input logic bo);
        brownout_flag <= bo;
        repeat (3) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        brownout_flag <= 1'b0;
    endtask : pin_reset

    task automatic t_stack();
        flow_req_s f;
        f = '0;
        f.ret = 1'b1;
        wreg(IDX_HOLD, 8'h1A);
        for (int i = 1; i <= 10; i++) begin
            flow_op(fj(1'b1, TGT_W'(i)), 13'h1800 | PC_W'(i));
        end
        for (int k = 0; k < 9; k++) begin
            flow_op(f, 13'h1800 | ((k == 8) ? 13'h0009 : PC_W'(9 - k)));
        end
        f = '0;
        f.vector = 1'b1;
        flow_op(f, PC_VECTOR);
        f = '0;
        f.ret = 1'b1;
        flow_op(f, 13'h1809);
        @(posedge pclk);
        flow <= fj(1'b1, 11'h055);
        @(posedge pclk);
        flow <= f;
        @(posedge pclk);
        flow <= '0;
        #1;
        check({19'h0, pc}, 32'h00001809, "call then return");
        rchk(IDX_HOLD, 8'h1A);
    endtask : t_stack

    task automatic t_pcl();
        flow_req_s f;
        wreg(IDX_HOLD, 8'h15);
        wreg(IDX_PCL, 8'hA7);
        #1;
        check({19'h0, pc}, 32'h000015A7, "pc after low byte write");
        rchk(IDX_PCL, 8'hA7);
        f = '0;
        f.pcl_wr = 1'b1;
        f.pcl_data = 8'h3C;
        flow_op(f, 13'h153C);
        flow_op(fj(1'b0, 11'h7FF), 13'h17FF);
        f = '0;
        f.step = 1'b1;
        flow_op(f, 13'h1800);
    endtask : t_pcl

    task automatic t_cause();
        logic [31:0] rd;
        logic        err;
        rchk(IDX_CAUSE, 8'h00);
        wreg(IDX_CAUSE, 8'hFF);
        rchk(IDX_CAUSE, 8'h03);
        pin_reset(1'b0);
        check({19'h0, pc}, 32'h0, "pc after pin reset");
        rchk(IDX_CAUSE, 8'h03);
        flow_op(fj(1'b0, 11'h123), 13'h0123);
        pin_reset(1'b1);
        check({19'h0, pc}, 32'h0, "pc after brown-out");
        rchk(IDX_CAUSE, 8'h02);
        wreg(IDX_CAUSE, 8'h03);
        bo_cfg <= 1'b0;
        pin_reset(1'b1);
        rchk(IDX_CAUSE, 8'h03);
        bo_cfg <= 1'b1;
        apb(1'b0, 8'h55, 8'h00, rd, err);
        check({31'h0, err}, 32'h1, "unmapped index error");
        check(rd, 32'h0, "unmapped index data");
    endtask : t_cause

    task automatic t_irq();
        wreg(IDX_EN, 8'h00);
        @(posedge pclk);
        irq_event <= 8'h08;
        @(posedge pclk);
        irq_event <= 8'h00;
        rchk(IDX_FLAG, 8'h08);
        check({31'h0, irq_pending}, 32'h0, "pending while masked");
        wreg(IDX_FLAG, 8'h00);
        wreg(IDX_EN, 8'h08);
        @(posedge pclk);
        irq_event <= 8'h08;
        @(posedge pclk);
        irq_event <= 8'h00;
        repeat (3) @(posedge pclk);
        check({31'h0, irq_pending}, 32'h1, "pending when enabled");
    endtask : t_irq

    task automatic t_ind();
        int w0;
        wreg(IDX_PTR, 8'h25);
        wreg(IDX_STATUS, 8'h80);
        file_op(1'b1, 1'b0, 8'h00, 3'b100);
        check({23'h0, mem.addr}, 32'h025, "indirect address");
        file_op(1'b0, 1'b1, 8'h30, 3'b010);
        check({23'h0, mem.addr}, 32'h030, "direct address");
        wreg(IDX_PTR, 8'h80);
        file_op(1'b1, 1'b0, 8'h00, 3'b001);
        w0 = wr_count;
        file_op(1'b0, 1'b1, 8'h00, 3'b000);
        @(posedge pclk);
        #1;
        check(32'(wr_count), 32'(w0), "self write stored");
        check(32'(rd_count), 32'd1, "self read reached memory");
        check({23'h0, last_addr}, 32'h030, "last memory address");
        rchk(IDX_IND, 8'h00);
    endtask : t_ind

    initial begin
        presetn <= 1'b0;
        por_rstn <= 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        flow = '0;
        file = '0;
        irq_event = 8'h00;
        brownout_flag = 1'b0;
        bo_cfg = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        por_rstn <= 1'b1;
        t_stack();
        $display("test stack done");
        t_pcl();
        $display("test pc load done");
        t_cause();
        $display("test reset cause done");
        t_irq();
        $display("test flags done");
        t_ind();
        $display("test indirect done");
        stop_test();
    end
endmodule : pc_stack_indirect_core_test
